// [tsw_pkg.sv]
// Constants for the two-stage watchdog timer
// What this block does
// - Free-running counter restarted by software never reaches terminal count when kept serviced.
// - Two-bit select picks first-stage interval of 2^15, 2^18, 2^21 or 2^24 clocks.
// - First-stage expiry raises interrupt request only when the interrupt is enabled.
// - Reset stage begins exactly 512 clocks after the interrupt stage, for every code.
// - No restart by end of second stage asserts system reset only when the reset is enabled; otherwise counting resumes.
// - Counter advances once per system clock; the select field only sets the terminal count.
// - Any internal reset, watchdog included, drives the active-low reset pin low.
package tsw_pkg;
    localparam int          TSW_CNT_W       = 24;
    localparam int          TSW_SHIFT_BASE  = 15;
    localparam int          TSW_SHIFT_STEP  = 3;
    localparam logic [9:0]  TSW_RST_DELAY   = 10'h200;
    localparam logic [9:0]  TSW_RST_HOLD    = 10'h004;
    localparam logic [23:0] TSW_CNT_RST     = 24'h000000;

    typedef enum logic [2:0] {
        TSW_ST_COUNT = 3'b001,
        TSW_ST_WARN  = 3'b010,
        TSW_ST_RESET = 3'b100
    } tsw_state_t;
endpackage

// [tsw_watchdog.sv]
// Two-stage watchdog timer core
`timescale 1ns/1ps
`default_nettype none
module tsw_watchdog
    import tsw_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic       restart,
    input  wire logic [1:0] timeout_interval_select,
    input  wire logic       wdt_int_enable,
    input  wire logic       wdt_reset_enable,
    input  wire logic       other_int_reset,
    output logic            wdt_irq,
    output logic            wdt_sys_reset,
    output logic            wdt_timeout_flag,
    output logic            reset_pin_out,
    output logic            reset_pin_oe
);
    // Terminal count of first stage for a select code
    function automatic logic [TSW_CNT_W-1:0] tsw_term(input logic [1:0] sel);
        int sh;
        sh = TSW_SHIFT_BASE + TSW_SHIFT_STEP * int'(sel);
        tsw_term = TSW_CNT_W'((64'h1 << sh) - 64'h1);
    endfunction

    tsw_state_t           st_q, st_d;
    logic [TSW_CNT_W-1:0] cnt_q, cnt_d;
    logic [9:0]           sub_q, sub_d;
    logic                 flag_q, flag_d;
    logic                 irq_q, irq_d;
    logic                 rst_q, rst_d;
    logic                 pin_q, pin_d;

    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        sub_d  = sub_q;
        flag_d = flag_q;
        irq_d  = 1'b0;
        rst_d  = 1'b0;
        case (st_q)
            TSW_ST_COUNT: begin
                if (restart) begin
                    cnt_d = TSW_CNT_RST;
                end else if (cnt_q == tsw_term(timeout_interval_select)) begin
                    cnt_d  = TSW_CNT_RST;
                    sub_d  = 10'h001;
                    flag_d = 1'b1;
                    st_d   = TSW_ST_WARN;
                    irq_d  = wdt_int_enable;
                end else begin
                    cnt_d = cnt_q + 24'h000001;
                end
            end
            TSW_ST_WARN: begin
                irq_d = wdt_int_enable;
                if (restart) begin
                    cnt_d = TSW_CNT_RST;
                    sub_d = 10'h000;
                    irq_d = 1'b0;
                    st_d  = TSW_ST_COUNT;
                end else if (sub_q == TSW_RST_DELAY) begin
                    sub_d = 10'h001;
                    irq_d = 1'b0;
                    if (wdt_reset_enable) begin
                        st_d  = TSW_ST_RESET;
                        rst_d = 1'b1;
                    end else begin
                        st_d = TSW_ST_COUNT;
                    end
                end else begin
                    sub_d = sub_q + 10'h001;
                end
            end
            TSW_ST_RESET: begin
                rst_d = 1'b1;
                if (sub_q == TSW_RST_HOLD) begin
                    sub_d = 10'h000;
                    rst_d = 1'b0;
                    st_d  = TSW_ST_COUNT;
                end else begin
                    sub_d = sub_q + 10'h001;
                end
            end
            default: begin
                st_d  = TSW_ST_COUNT;
                cnt_d = TSW_CNT_RST;
                sub_d = 10'h000;
            end
        endcase
        if (restart) begin
            flag_d = 1'b0;
        end
        pin_d = rst_d | other_int_reset;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_q   <= TSW_ST_COUNT;
            cnt_q  <= TSW_CNT_RST;
            sub_q  <= 10'h000;
            flag_q <= 1'b0;
            irq_q  <= 1'b0;
            rst_q  <= 1'b0;
            pin_q  <= 1'b0;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            sub_q  <= sub_d;
            flag_q <= flag_d;
            irq_q  <= irq_d;
            rst_q  <= rst_d;
            pin_q  <= pin_d;
        end
    end

    assign wdt_irq          = irq_q;
    assign wdt_sys_reset    = rst_q;
    assign wdt_timeout_flag = flag_q;
    assign reset_pin_out    = 1'b0;
    assign reset_pin_oe     = pin_q;
endmodule
`default_nettype wire

// [tsw_watchdog_assertions.sv]
// Watchdog checks
`timescale 1ns/1ps
`default_nettype none
module tsw_chk (
    input wire logic core_clk, sys_rst, restart, wdt_int_enable, wdt_reset_enable, other_int_reset,
    input wire logic wdt_irq, wdt_sys_reset, wdt_timeout_flag, reset_pin_out, reset_pin_oe);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // Watchdog reset stays up for the hold time, then drops
    sequence s_rst_hold;
        wdt_sys_reset[*4] ##1 !wdt_sys_reset;
    endsequence
    AST_IRQ_EN: assert property (!$past(wdt_int_enable) |-> !wdt_irq) else $error("ien");
    AST_IRQ_ON: assert property ($rose(wdt_timeout_flag) && $past(wdt_int_enable) |-> wdt_irq) else $error("irq");
    AST_GAP: assert property ($rose(wdt_sys_reset) |-> $past(wdt_timeout_flag, 512)) else $error("gap");
    AST_HOLD: assert property ($rose(wdt_sys_reset) |-> s_rst_hold) else $error("rst");
    AST_EN: assert property ($rose(wdt_sys_reset) |-> $past(wdt_reset_enable)) else $error("en");
    AST_OE: assert property ((wdt_sys_reset || $past(other_int_reset)) |-> reset_pin_oe) else $error("oe");
    AST_OE_ONLY: assert property (reset_pin_oe |-> (wdt_sys_reset || $past(other_int_reset))) else $error("oe src");
    AST_LOW: assert property (reset_pin_oe |-> !reset_pin_out) else $error("pin");
    AST_KICK: assert property (restart |=> !wdt_timeout_flag && !wdt_sys_reset) else $error("kick");
endmodule
bind tsw_watchdog tsw_chk u_chk (.*);
`default_nettype wire

// [two_stage_watchdog_timer_tb.sv]
// Watchdog bench
`timescale 1ns/1ps
`default_nettype none
`define CHK(s, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; $display("Error %s %0d %0d", s, e, g); end end
module two_stage_watchdog_timer_tb;
    logic core_clk = 0, sys_rst = 1, restart = 0, wdt_int_enable = 1, wdt_reset_enable = 1, other_int_reset = 0;
    logic wdt_irq, wdt_sys_reset, wdt_timeout_flag, reset_pin_out, reset_pin_oe;
    logic [1:0] sel = 2'h0;
    int fails, num_checks, n;
    tsw_watchdog dut (
        .core_clk                (core_clk),
        .sys_rst                 (sys_rst),
        .restart                 (restart),
        .timeout_interval_select (sel),
        .wdt_int_enable          (wdt_int_enable),
        .wdt_reset_enable        (wdt_reset_enable),
        .other_int_reset         (other_int_reset),
        .wdt_irq                 (wdt_irq),
        .wdt_sys_reset           (wdt_sys_reset),
        .wdt_timeout_flag        (wdt_timeout_flag),
        .reset_pin_out           (reset_pin_out),
        .reset_pin_oe            (reset_pin_oe)
    );
    initial forever #25 core_clk = ~core_clk;
    task tally_and_finish;
        $display("%0d checks %0d fails", num_checks, fails);
        if (!fails && num_checks) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task wt(bit rst);
        restart = !rst;
        @(negedge core_clk) restart = 0;
        for (n = rst; n < 33000 && !(rst ? wdt_sys_reset : wdt_timeout_flag); n++)
            @(negedge core_clk);
    endtask
    task t_full;
        wt(0);
        `CHK("irq t", 1 << tsw_pkg::TSW_SHIFT_BASE, n)
        `CHK("irq on", 1, wdt_irq)
        wt(1);
        `CHK("rst t", 512, n)
        `CHK("pin oe", 1, reset_pin_oe)
        `CHK("pin out", 0, reset_pin_out)
        `CHK("irq end", 0, wdt_irq)
        repeat (8) @(negedge core_clk);
    endtask
    task t_other;
        other_int_reset = 1;
        @(negedge core_clk) other_int_reset = 0;
        `CHK("oe other", 1, reset_pin_oe)
        @(negedge core_clk);
        `CHK("oe off", 0, reset_pin_oe)
    endtask
    task t_cancel;
        wdt_int_enable = 0;
        wt(0);
        `CHK("irq off", 0, wdt_irq)
        repeat (100) @(negedge core_clk);
        sel = 2'h1;
        wt(0);
        `CHK("rerun", 33000, n)
        `CHK("no rst", 0, wdt_sys_reset)
        `CHK("flag clr", 0, wdt_timeout_flag)
    endtask
    initial begin
        repeat (10) @(negedge core_clk);
        sys_rst = 0;
        t_full();
        t_other();
        t_cancel();
        tally_and_finish();
    end
    initial #6000000 begin
        fails++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
